// file: include/smbus_status_defs.svh
`ifndef SMBUS_STATUS_DEFS_SVH
`define SMBUS_STATUS_DEFS_SVH
`define BSC_OFFSET 8'hc1
`define BSC_RESET 8'hf8
`define ST_BUS_ERR 8'h00
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_MT_SLA_ACK 8'h18
`define ST_MT_SLA_NACK 8'h20
`define ST_MT_DAT_ACK 8'h28
`define ST_MT_DAT_NACK 8'h30
`define ST_MT_ARB_LOST 8'h38
`define ST_MR_SLA_ACK 8'h40
`define ST_MR_SLA_NACK 8'h48
`define ST_MR_DAT_ACK 8'h50
`define ST_MR_DAT_NACK 8'h58
`define ST_SR_OWN 8'h60
`define ST_SR_ARB_OWN 8'h68
`define ST_SR_GC 8'h70
`define ST_SR_ARB_GC 8'h78
`define ST_SR_OWN_DAT_ACK 8'h80
`define ST_SR_OWN_DAT_NACK 8'h88
`define ST_SR_GC_DAT_ACK 8'h90
`define ST_SR_GC_DAT_NACK 8'h98
`define ST_SR_STOP 8'ha0
`define ST_ST_OWN 8'ha8
`define ST_ST_ARB_OWN 8'hb0
`define ST_ST_DAT_ACK 8'hb8
`define ST_ST_DAT_NACK 8'hc0
`define ST_ST_LAST_ACK 8'hc8
`define ST_TIMEOUT 8'hd0
`define ST_IDLE 8'hf8
`define GC_ADDR 7'h00
`define LOW3_ZERO 3'h0
`endif

// file: include/smbus_status_pkg.sv
package smbus_status_pkg;
  typedef enum logic [3:0] {
    EV_NONE = 4'b0000,
    EV_BUS_ERR = 4'b0001,
    EV_START = 4'b0010,
    EV_RSTART = 4'b0011,
    EV_ADDR_DONE = 4'b0100,
    EV_DATA_DONE = 4'b0101,
    EV_ARB_LOST = 4'b0110,
    EV_STOP = 4'b0111,
    EV_TIMEOUT = 4'b1000,
    EV_IDLE = 4'b1001
  } bus_event_t;
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_MT = 3'b001,
    MD_MR = 3'b010,
    MD_SR_OWN = 3'b011,
    MD_SR_GC = 3'b100,
    MD_ST = 3'b101
  } mode_t;
endpackage

// file: include/event_if.sv
`timescale 1ns/100ps
interface event_if;
  import smbus_status_pkg::*;
  logic valid;
  bus_event_t ev;
  logic rw_bit;
  logic acked;
  logic [6:0] addr;
  logic ack_en;
  logic [7:0] code;
  modport src (output valid, ev, rw_bit, acked, addr, ack_en, input code);
  modport enc (input valid, ev, rw_bit, acked, addr, ack_en, output code);
endinterface

// file: core/state_encoder.sv
`timescale 1ns/100ps
`include "smbus_status_defs.svh"
module state_encoder
  import smbus_status_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Addressing config
  input wire logic [6:0] i_own_addr,
  input wire logic i_gc_en,
  input wire logic i_master,
  // Events
  event_if.enc ev_port
);
  mode_t mode_r, mode_nxt;
  logic arb_r, arb_nxt;
  wire own_hit = ev_port.addr == i_own_addr;
  wire gc_hit = i_gc_en && ev_port.addr == `GC_ADDR;
  wire slave_mode = mode_r == MD_SR_OWN || mode_r == MD_SR_GC || mode_r == MD_ST;
  logic [7:0] code_c;

  always_comb begin
    code_c = `ST_IDLE;
    mode_nxt = mode_r;
    arb_nxt = arb_r;
    case (ev_port.ev)
      EV_BUS_ERR: begin
        code_c = `ST_BUS_ERR;
        mode_nxt = MD_IDLE;
      end
      EV_START: begin
        code_c = `ST_START;
        arb_nxt = 1'b0;
      end
      EV_RSTART: begin
        code_c = slave_mode ? `ST_SR_STOP : `ST_RSTART;
        if (slave_mode) mode_nxt = MD_IDLE;
      end
      EV_ARB_LOST: begin
        code_c = `ST_MT_ARB_LOST;
        arb_nxt = 1'b1;
        mode_nxt = MD_IDLE;
      end
      EV_ADDR_DONE: begin
        if (i_master && !arb_r) begin
          if (!ev_port.rw_bit) begin
            code_c = ev_port.acked ? `ST_MT_SLA_ACK : `ST_MT_SLA_NACK;
            mode_nxt = MD_MT;
          end else begin
            code_c = ev_port.acked ? `ST_MR_SLA_ACK : `ST_MR_SLA_NACK;
            mode_nxt = MD_MR;
          end
        end else if (gc_hit && !ev_port.rw_bit) begin
          code_c = arb_r ? `ST_SR_ARB_GC : `ST_SR_GC;
          mode_nxt = MD_SR_GC;
        end else if (own_hit && !ev_port.rw_bit) begin
          code_c = arb_r ? `ST_SR_ARB_OWN : `ST_SR_OWN;
          mode_nxt = MD_SR_OWN;
        end else if (own_hit) begin
          code_c = arb_r ? `ST_ST_ARB_OWN : `ST_ST_OWN;
          mode_nxt = MD_ST;
        end
        arb_nxt = 1'b0;
      end
      EV_DATA_DONE: begin
        case (mode_r)
          MD_MT: code_c = ev_port.acked ? `ST_MT_DAT_ACK : `ST_MT_DAT_NACK;
          MD_MR: code_c = ev_port.acked ? `ST_MR_DAT_ACK : `ST_MR_DAT_NACK;
          MD_SR_OWN: code_c = ev_port.acked ? `ST_SR_OWN_DAT_ACK : `ST_SR_OWN_DAT_NACK;
          MD_SR_GC: code_c = ev_port.acked ? `ST_SR_GC_DAT_ACK : `ST_SR_GC_DAT_NACK;
          MD_ST: begin
            if (!ev_port.ack_en && ev_port.acked) code_c = `ST_ST_LAST_ACK;
            else code_c = ev_port.acked ? `ST_ST_DAT_ACK : `ST_ST_DAT_NACK;
          end
          default: code_c = `ST_IDLE;
        endcase
      end
      EV_STOP: begin
        code_c = slave_mode ? `ST_SR_STOP : `ST_IDLE;
        mode_nxt = MD_IDLE;
      end
      EV_TIMEOUT: begin
        code_c = `ST_TIMEOUT;
        mode_nxt = MD_IDLE;
      end
      default: code_c = `ST_IDLE;
    endcase
  end

  assign ev_port.code = code_c;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_r <= MD_IDLE;
      arb_r <= 1'b0;
    end else if (ev_port.valid) begin
      mode_r <= mode_nxt;
      arb_r <= arb_nxt;
    end
  end
endmodule // state_encoder

// file: core/smbus_state_status_reporter.sv
`timescale 1ns/100ps
`include "smbus_status_defs.svh"
// How it works
// - Eight-bit read-only code, one per state
// - Low three bits zero while flag set
// - Bus error gives 00, idle gives F8
// - Start 08, repeated start 10
// - Master write address: 18 ack, 20 nack
// - Master data sent: 28 ack, 30 nack
// - Master read address: 40 ack, 48 nack
// - Master data received: 50 ack, 58 nack
// - Arbitration lost 38; addressed 68/78/B0
// - Own address write acked gives 60
// - General call acked gives 70
// - Own-address data: 80 ack, 88 nack
// - General-call data: 90 ack, 98 nack
// - Stop or restart while slave gives A0
// - Own address read acked gives A8
// - Slave sent byte: B8, C0, last C8
// - Enabled clock-high timeout gives D0
// - Reset value is idle code F8
// - General call only when enable set
module smbus_state_status_reporter
  import smbus_status_pkg::*;
#(
  parameter logic [7:0] REG_ADDR = `BSC_OFFSET
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Controller events
  input wire logic i_ev_valid,
  input wire bus_event_t i_ev,
  input wire logic i_rw_bit,
  input wire logic i_acked,
  input wire logic [6:0] i_addr,
  input wire logic i_master,
  // Configuration
  input wire logic [7:0] i_own_slave_address,
  input wire logic i_acknowledge_enable,
  input wire logic i_clock_high_timeout_enable,
  input wire logic i_si_clear,
  // Status
  output logic o_si,
  output logic [7:0] o_bus_state_code
);
  event_if evb ();
  logic [7:0] code_r;
  logic si_r;

  wire timeout_blocked = i_ev == EV_TIMEOUT && !i_clock_high_timeout_enable;
  wire ev_take = i_ev_valid && !timeout_blocked;
  wire hold = si_r && !i_si_clear;
  wire ev_load = ev_take && !hold;
  wire rd_hit = i_reg_rd && i_reg_addr == REG_ADDR;

  assign evb.valid = ev_load;
  assign evb.ev = i_ev;
  assign evb.rw_bit = i_rw_bit;
  assign evb.acked = i_acked;
  assign evb.addr = i_addr;
  assign evb.ack_en = i_acknowledge_enable;

  state_encoder u_enc (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_own_addr(i_own_slave_address[7:1]),
    .i_gc_en(i_own_slave_address[0]),
    .i_master(i_master),
    .ev_port(evb)
  );

  // Code register, read-only to software
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      code_r <= `BSC_RESET;
    end else if (ev_load) begin
      code_r <= {evb.code[7:3], `LOW3_ZERO};
    end
  end

  // Set wins over clear
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      si_r <= 1'b0;
    end else if (ev_load) begin
      si_r <= 1'b1;
    end else if (i_si_clear) begin
      si_r <= 1'b0;
    end
  end

  assign o_si = si_r;
  assign o_bus_state_code = code_r;
  assign o_reg_rdata = rd_hit ? code_r : 8'h00;

  // Checker helpers, read only by the properties below
  wire addr_ev = ev_load && i_ev == EV_ADDR_DONE;
  wire data_ev = ev_load && i_ev == EV_DATA_DONE;
  wire own_match = i_addr == i_own_slave_address[7:1];

  // Code families; each one pins down the mode for a data byte
  function automatic logic mt_code(input logic [7:0] c);
    return c == `ST_MT_SLA_ACK || c == `ST_MT_SLA_NACK || c == `ST_MT_DAT_ACK ||
      c == `ST_MT_DAT_NACK;
  endfunction

  function automatic logic mr_code(input logic [7:0] c);
    return c == `ST_MR_SLA_ACK || c == `ST_MR_SLA_NACK || c == `ST_MR_DAT_ACK ||
      c == `ST_MR_DAT_NACK;
  endfunction

  function automatic logic own_rx_code(input logic [7:0] c);
    return c == `ST_SR_OWN || c == `ST_SR_ARB_OWN || c == `ST_SR_OWN_DAT_ACK ||
      c == `ST_SR_OWN_DAT_NACK;
  endfunction

  function automatic logic gc_rx_code(input logic [7:0] c);
    return c == `ST_SR_GC || c == `ST_SR_ARB_GC || c == `ST_SR_GC_DAT_ACK ||
      c == `ST_SR_GC_DAT_NACK;
  endfunction

  function automatic logic st_code(input logic [7:0] c);
    return c == `ST_ST_OWN || c == `ST_ST_ARB_OWN || c == `ST_ST_DAT_ACK ||
      c == `ST_ST_DAT_NACK || c == `ST_ST_LAST_ACK;
  endfunction

  // All 28 legal codes
  function automatic logic state_code(input logic [7:0] c);
    return mt_code(c) || mr_code(c) || own_rx_code(c) || gc_rx_code(c) || st_code(c) ||
      c == `ST_BUS_ERR || c == `ST_START || c == `ST_RSTART || c == `ST_MT_ARB_LOST ||
      c == `ST_SR_STOP || c == `ST_TIMEOUT || c == `ST_IDLE;
  endfunction

  property p_low_zero;
    @(posedge i_ref_clk) disable iff (!i_nrst) si_r |-> code_r[2:0] == `LOW3_ZERO;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits not zero");
  property p_hold_code;
    @(posedge i_ref_clk) disable iff (!i_nrst) si_r && !i_si_clear |=> $stable(code_r);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("code changed while flag set");
  property p_legal_code;
    @(posedge i_ref_clk) disable iff (!i_nrst) si_r |-> state_code(code_r);
  endproperty
  a_legal_code: assert property (p_legal_code) else $error("code not a legal state");
  property p_reset_idle;
    @(posedge i_ref_clk) !i_nrst ##1 !i_nrst |-> code_r == `BSC_RESET && !si_r;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset code not idle");
  property p_set_flag;
    @(posedge i_ref_clk) disable iff (!i_nrst) ev_load |=> si_r && code_r == $past(evb.code);
  endproperty
  a_set_flag: assert property (p_set_flag) else $error("flag or code not loaded");
  property p_bus_err;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_BUS_ERR |=> code_r == `ST_BUS_ERR;
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error code wrong");
  property p_start;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_START |=> code_r == `ST_START;
  endproperty
  a_start: assert property (p_start) else $error("start code wrong");
  property p_timeout_off;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      i_ev_valid && i_ev == EV_TIMEOUT && !i_clock_high_timeout_enable && !si_r
      |=> !si_r;
  endproperty
  a_timeout_off: assert property (p_timeout_off) else $error("timeout taken while off");
  property p_timeout;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_TIMEOUT |=> code_r == `ST_TIMEOUT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout code wrong");
  property p_gc_off;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_ADDR_DONE && !i_own_slave_address[0] |=>
      code_r != `ST_SR_GC && code_r != `ST_SR_ARB_GC;
  endproperty
  a_gc_off: assert property (p_gc_off) else $error("general call while disabled");
  property p_read;
    @(posedge i_ref_clk) disable iff (!i_nrst) rd_hit |-> o_reg_rdata == code_r;
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  property p_arb_lost;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_ARB_LOST |=> code_r == `ST_MT_ARB_LOST;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("arbitration code wrong");
  property p_rstart;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_RSTART |=> code_r == `ST_RSTART || code_r == `ST_SR_STOP;
  endproperty
  a_rstart: assert property (p_rstart) else $error("restart code wrong");
  property p_stop;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_STOP |=> code_r == `ST_SR_STOP || code_r == `ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop code wrong");
  property p_idle;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ev_load && i_ev == EV_IDLE |=> code_r == `ST_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle code wrong");
  property p_mt_addr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      addr_ev && i_master && !i_rw_bit && code_r != `ST_MT_ARB_LOST |=>
      code_r == ($past(i_acked) ? `ST_MT_SLA_ACK : `ST_MT_SLA_NACK);
  endproperty
  a_mt_addr: assert property (p_mt_addr) else $error("master write address code wrong");
  property p_mr_addr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      addr_ev && i_master && i_rw_bit && code_r != `ST_MT_ARB_LOST |=>
      code_r == ($past(i_acked) ? `ST_MR_SLA_ACK : `ST_MR_SLA_NACK);
  endproperty
  a_mr_addr: assert property (p_mr_addr) else $error("master read address code wrong");
  property p_gc_addr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      addr_ev && !i_master && i_own_slave_address[0] && i_addr == `GC_ADDR && !i_rw_bit
      |=> code_r == `ST_SR_GC || code_r == `ST_SR_ARB_GC;
  endproperty
  a_gc_addr: assert property (p_gc_addr) else $error("general call code wrong");
  property p_own_write;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      addr_ev && !i_master && own_match && i_addr != `GC_ADDR && !i_rw_bit
      |=> code_r == `ST_SR_OWN || code_r == `ST_SR_ARB_OWN;
  endproperty
  a_own_write: assert property (p_own_write) else $error("own write code wrong");
  property p_own_read;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      addr_ev && !i_master && own_match && i_rw_bit
      |=> code_r == `ST_ST_OWN || code_r == `ST_ST_ARB_OWN;
  endproperty
  a_own_read: assert property (p_own_read) else $error("own read code wrong");
  property p_mt_data;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      data_ev && mt_code(code_r) |=>
      code_r == ($past(i_acked) ? `ST_MT_DAT_ACK : `ST_MT_DAT_NACK);
  endproperty
  a_mt_data: assert property (p_mt_data) else $error("master sent data code wrong");
  property p_mr_data;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      data_ev && mr_code(code_r) |=>
      code_r == ($past(i_acked) ? `ST_MR_DAT_ACK : `ST_MR_DAT_NACK);
  endproperty
  a_mr_data: assert property (p_mr_data) else $error("master received data code wrong");
  property p_own_data;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      data_ev && own_rx_code(code_r) |=>
      code_r == ($past(i_acked) ? `ST_SR_OWN_DAT_ACK : `ST_SR_OWN_DAT_NACK);
  endproperty
  a_own_data: assert property (p_own_data) else $error("own data code wrong");
  property p_gc_data;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      data_ev && gc_rx_code(code_r) |=>
      code_r == ($past(i_acked) ? `ST_SR_GC_DAT_ACK : `ST_SR_GC_DAT_NACK);
  endproperty
  a_gc_data: assert property (p_gc_data) else $error("general call data code wrong");
  property p_st_data;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      data_ev && st_code(code_r) && (i_acknowledge_enable || !i_acked) |=>
      code_r == ($past(i_acked) ? `ST_ST_DAT_ACK : `ST_ST_DAT_NACK);
  endproperty
  a_st_data: assert property (p_st_data) else $error("slave sent data code wrong");
  property p_st_last;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      data_ev && st_code(code_r) && !i_acknowledge_enable && i_acked |=>
      code_r == `ST_ST_LAST_ACK;
  endproperty
  a_st_last: assert property (p_st_last) else $error("last byte code wrong");

  c_start: cover property (@(posedge i_ref_clk) ev_load && i_ev == EV_START);
  c_clear: cover property (@(posedge i_ref_clk) si_r ##1 !si_r);
  c_slave: cover property (@(posedge i_ref_clk) code_r == `ST_SR_OWN);
  c_set_wins: cover property (@(posedge i_ref_clk) ev_load && si_r && i_si_clear);
  c_arb_own: cover property (@(posedge i_ref_clk) code_r == `ST_SR_ARB_OWN);
endmodule // smbus_state_status_reporter

// file: tb/bus_partner.sv
`timescale 1ns/100ps
module bus_partner
  import smbus_status_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Controller events
  output logic o_ev_valid,
  output bus_event_t o_ev,
  output logic o_rw_bit,
  output logic o_acked,
  output logic o_master,
  output logic [6:0] o_addr
);
  initial begin
    o_ev_valid = 1'b0;
    o_ev = EV_NONE;
    {o_rw_bit, o_acked, o_master, o_addr} = 10'h3ff;
  end
  // One-cycle pulse; qualifiers scrambled once released
  task automatic send(input bus_event_t e, input logic [9:0] f);
    @(posedge i_ref_clk);
    #1;
    o_ev_valid = 1'b1;
    o_ev = e;
    {o_rw_bit, o_acked, o_master, o_addr} = f;
    @(posedge i_ref_clk);
    #1;
    o_ev_valid = 1'b0;
    o_ev = EV_NONE;
    {o_rw_bit, o_acked, o_master, o_addr} = ~f;
  endtask
endmodule // bus_partner

// file: tb/smbus_state_status_reporter_tb.sv
`timescale 1ns/100ps
module smbus_state_status_reporter_tb;
  import smbus_status_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] raddr = 8'hc1;
  // Read strobe only; no write path to the status register
  logic rd = 1'b1;
  logic [7:0] own = 8'h6b;
  logic ack_en = 1'b1;
  logic tmo_en = 1'b1;
  logic si_clr = 1'b0;
  logic ev_v, rw, ak, ms, si;
  bus_event_t ev;
  logic [6:0] adr;
  logic [7:0] rdata, code;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  bus_partner i_bus_partner (.i_ref_clk(clk), .o_ev_valid(ev_v), .o_ev(ev), .o_rw_bit(rw),
    .o_acked(ak), .o_master(ms), .o_addr(adr));
  smbus_state_status_reporter i_smbus_state_status_reporter (.i_ref_clk(clk), .i_nrst(nrst),
    .i_reg_addr(raddr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_ev_valid(ev_v), .i_ev(ev),
    .i_rw_bit(rw), .i_acked(ak), .i_addr(adr), .i_master(ms), .i_own_slave_address(own),
    .i_acknowledge_enable(ack_en), .i_clock_high_timeout_enable(tmo_en),
    .i_si_clear(si_clr), .o_si(si), .o_bus_state_code(code));

  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clear_si;
    @(posedge clk);
    #1;
    si_clr = 1'b1;
    @(posedge clk);
    #1;
    si_clr = 1'b0;
  endtask

  // Event, then flag, code and register read, then flag cleared
  task automatic step(input bus_event_t e, input logic r, a, m, input logic [6:0] ad,
                      input logic [7:0] exp);
    i_bus_partner.send(e, {r, a, m, ad});
    check({7'h00, si}, 8'h01);
    check(code, exp);
    check(rdata, exp);
    clear_si();
  endtask

  task automatic sc_master_tx;
    step(EV_START, 0, 0, 1, 7'h00, 8'h08);
    step(EV_ADDR_DONE, 0, 1, 1, 7'h50, 8'h18);
    step(EV_DATA_DONE, 0, 1, 1, 7'h50, 8'h28);
    step(EV_DATA_DONE, 0, 0, 1, 7'h50, 8'h30);
    step(EV_RSTART, 0, 0, 1, 7'h00, 8'h10);
    step(EV_ADDR_DONE, 0, 0, 1, 7'h50, 8'h20);
    step(EV_BUS_ERR, 0, 0, 1, 7'h00, 8'h00);
    step(EV_STOP, 0, 0, 1, 7'h00, 8'hf8);
  endtask

  task automatic sc_master_rx;
    step(EV_START, 0, 0, 1, 7'h00, 8'h08);
    step(EV_ADDR_DONE, 1, 1, 1, 7'h50, 8'h40);
    step(EV_DATA_DONE, 1, 1, 1, 7'h50, 8'h50);
    step(EV_DATA_DONE, 1, 0, 1, 7'h50, 8'h58);
    step(EV_RSTART, 0, 0, 1, 7'h00, 8'h10);
    step(EV_ADDR_DONE, 1, 0, 1, 7'h50, 8'h48);
    step(EV_STOP, 0, 0, 1, 7'h00, 8'hf8);
  endtask

  task automatic sc_slave;
    step(EV_ADDR_DONE, 0, 1, 0, 7'h35, 8'h60);
    step(EV_DATA_DONE, 0, 1, 0, 7'h35, 8'h80);
    step(EV_DATA_DONE, 0, 0, 0, 7'h35, 8'h88);
    step(EV_STOP, 0, 0, 0, 7'h00, 8'ha0);
    step(EV_ADDR_DONE, 0, 1, 0, 7'h00, 8'h70);
    step(EV_DATA_DONE, 0, 1, 0, 7'h00, 8'h90);
    step(EV_DATA_DONE, 0, 0, 0, 7'h00, 8'h98);
    step(EV_RSTART, 0, 0, 0, 7'h00, 8'ha0);
    step(EV_ADDR_DONE, 1, 1, 0, 7'h35, 8'ha8);
    step(EV_DATA_DONE, 1, 1, 0, 7'h35, 8'hb8);
    ack_en = 1'b0;
    step(EV_DATA_DONE, 1, 1, 0, 7'h35, 8'hc8);
    ack_en = 1'b1;
    step(EV_DATA_DONE, 1, 0, 0, 7'h35, 8'hc0);
    step(EV_TIMEOUT, 0, 0, 0, 7'h00, 8'hd0);
    tmo_en = 1'b0;
    i_bus_partner.send(EV_TIMEOUT, 10'h000);
    check({7'h00, si}, 8'h00);
    tmo_en = 1'b1;
    step(EV_IDLE, 0, 0, 0, 7'h00, 8'hf8);
  endtask

  task automatic sc_arb;
    logic [7:0] exp_c [3] = '{8'h68, 8'h78, 8'hb0};
    for (int i = 0; i < 3; i++) begin
      step(EV_START, 0, 0, 1, 7'h00, 8'h08);
      step(EV_ARB_LOST, 0, 0, 1, 7'h00, 8'h38);
      step(EV_ADDR_DONE, i == 2, 1, 0, (i == 1) ? 7'h00 : 7'h35, exp_c[i]);
      step(EV_STOP, 0, 0, 0, 7'h00, 8'ha0);
    end
    own = 8'h6a;
    i_bus_partner.send(EV_ADDR_DONE, 10'h000);
    check({7'h00, code == 8'h70}, 8'h00);
    clear_si();
    own = 8'h6b;
  endtask

  task automatic sc_hold;
    i_bus_partner.send(EV_START, 10'h080);
    i_bus_partner.send(EV_BUS_ERR, 10'h080);
    check(code, 8'h08);
    @(posedge clk);
    #1;
    rd = 1'b0;
    #10;
    check(rdata, 8'h00);
    @(posedge clk);
    #1;
    raddr = 8'hc2;
    rd = 1'b1;
    #10;
    check(rdata, 8'h00);
    @(posedge clk);
    #1;
    raddr = 8'hc1;
    // Clear and event in one cycle: the event wins
    fork
      i_bus_partner.send(EV_BUS_ERR, 10'h080);
      begin
        @(posedge clk);
        #1;
        si_clr = 1'b1;
        @(posedge clk);
        #1;
        si_clr = 1'b0;
      end
    join
    check({7'h00, si}, 8'h01);
    check(code, 8'h00);
    clear_si();
    check({7'h00, si}, 8'h00);
    check(code, 8'h00);
    step(EV_STOP, 0, 0, 1, 7'h00, 8'hf8);
  endtask

  // Reset in mid-run returns code, flag and mode to idle
  task automatic sc_reset;
    step(EV_ADDR_DONE, 0, 1, 0, 7'h35, 8'h60);
    i_bus_partner.send(EV_START, 10'h080);
    @(posedge clk);
    #1;
    nrst = 1'b0;
    #10;
    check({7'h00, si}, 8'h00);
    check(code, 8'hf8);
    @(posedge clk);
    #1;
    nrst = 1'b1;
    check(rdata, 8'hf8);
    step(EV_STOP, 0, 0, 1, 7'h00, 8'hf8);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    check(code, 8'hf8);
    check(rdata, 8'hf8);
    sc_master_tx();
    sc_master_rx();
    sc_slave();
    sc_arb();
    sc_hold();
    sc_reset();
    complete_run();
  end
endmodule // smbus_state_status_reporter_tb
